//--- hdl/cac_pkg.sv
// package for the charger auxiliary control register bank
// assumes one 20 MHz reference clock
package cac_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SDA_TIMEOUT_MS = 1000;
  localparam int unsigned SDA_TIMEOUT_CYC = CLK_PER_MS * SDA_TIMEOUT_MS;
  localparam int unsigned LONG_PRESS_MS = 10000;
  localparam int unsigned LONG_PRESS_CYC = CLK_PER_MS * LONG_PRESS_MS;
  localparam int unsigned EOC_SHORT_MS = 2;
  localparam int unsigned EOC_SHORT_CYC = CLK_PER_MS * EOC_SHORT_MS;
  localparam int unsigned EOC_LONG_MS = 64;
  localparam int unsigned EOC_LONG_CYC = CLK_PER_MS * EOC_LONG_MS;
  localparam int unsigned ADAPTER_REQ_MS = 1;
  localparam int unsigned ADAPTER_REQ_CYC = CLK_PER_MS * ADAPTER_REQ_MS;

  // ************************************************************
  // register offsets (16-bit readings: high byte first)
  // ************************************************************
  localparam logic [7:0] ADDR_DIE_TEMP_HI = 8'h41;
  localparam logic [7:0] ADDR_DIE_TEMP_LO = 8'h42;
  localparam logic [7:0] ADDR_PLUS_MV_HI = 8'h43;
  localparam logic [7:0] ADDR_PLUS_MV_LO = 8'h44;
  localparam logic [7:0] ADDR_MINUS_MV_HI = 8'h45;
  localparam logic [7:0] ADDR_MINUS_MV_LO = 8'h46;
  localparam logic [7:0] ADDR_LINE_DRIVE = 8'h47;
  localparam logic [7:0] ADDR_PART_INFO = 8'h48;
  localparam logic [7:0] ADDR_ADAPTER_REQ = 8'h49;
  localparam logic [7:0] ADDR_CTRL_ZERO = 8'h4a;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h4b;
  localparam logic [7:0] ADDR_DONE_FLAGS = 8'h4d;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_PLUS_DRIVE = 5;
  localparam int POS_MINUS_DRIVE = 2;
  localparam int POS_PART_ID = 3;
  localparam int POS_REQ_GO = 7;
  localparam int POS_GEN_SEL = 6;
  localparam int POS_GEN1_DIR = 5;
  localparam int POS_BUS_TO_DIS = 7;
  localparam int POS_LONG_PRESS = 6;
  localparam int POS_AUTO_ICL = 5;
  localparam int POS_EOC_DEGL = 4;
  localparam int POS_EOC_RST = 3;
  localparam int POS_AUTO_FLOOR = 2;
  localparam int POS_COOL_SEL = 1;
  localparam int POS_EXTREME = 0;
  localparam int POS_FREQ_1MHZ = 4;
  localparam int POS_OTG_INPUT_PIN_ENABLE = 3;
  localparam int POS_OTG_GATE = 2;
  localparam int POS_DONE_FLAG = 4;

  // ************************************************************
  // reset values and code ladder
  // ************************************************************
  localparam logic [5:0] RST_DRIVE = 6'h00;
  localparam logic [7:0] RST_ADAPTER_REQ = 8'h00;
  localparam logic [7:0] RST_CTRL_ZERO = 8'h76;
  localparam logic [4:0] RST_CTRL_ONE = 5'h00;
  localparam logic [4:0] GEN2_TOP_CODE = 5'h1d;
  localparam logic [15:0] GEN2_BASE_MV = 16'h157c;
  localparam logic [15:0] GEN2_STEP_MV = 16'h01f4;
  localparam logic [4:0] GEN2_SELF_TEST = 5'h1e;
  localparam logic [4:0] GEN2_NO_DROP_COMP = 5'h1f;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } cac_bus_st_t;

endpackage

//--- hdl/cac_hold_timer.sv
// hold timer: one pulse after a level stays active long enough
// assumes i_active and i_limit come from logic on the same clock
`timescale 1ns/1ps
module cac_hold_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // condition and length
  input wire logic i_active,
  input wire logic [W-1:0] i_limit,
  // result
  output logic o_expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic fired;
    logic pulse;
  } cac_timer_t;

  cac_timer_t s_r;
  cac_timer_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    if (!i_active) begin
      s_nxt.cnt = '0;
      s_nxt.fired = 1'b0;
    end else if (!s_r.fired) begin
      // fires once per active run; a drop restarts the count
      if (s_r.cnt + W'(1) >= i_limit) begin
        s_nxt.fired = 1'b1;
        s_nxt.pulse = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_expired = s_r.pulse;

endmodule // cac_hold_timer

//--- hdl/cac_aux_regs.sv
// charger auxiliary registers behind an i2c target
// assumes converter readings and zone/detect strobes are on I_REF_CLK;
// scl, sda, button, bus presence, charge-done and otg pins are asynchronous
//
// Summary of operation
// - die temperature read, signed, 1 C/count
// - plus line reading, 1 mV/count
// - minus line reading, own register, 1 mV/count
// - 3-bit manual drive per data line
// - 4-bit part id in bits 6:3
// - request go set by write, hardware clears
// - select bit picks protocol generation
// - gen1 direction: zero lower, one raise
// - 5-bit gen2 code, self-test and compensation-off codes
// - target holding sda low 1 s resets target
// - button low 10 s opens ship switch
// - auto current limit after port detection
// - charge-done deglitch 2 ms or 64 ms
// - charge-done reset bit self-clears
// - auto input voltage floor at plug-in
// - cool zone may use warm voltage
// - cold/hot zones stop or continue charging
// - frequency override forces 1 MHz
// - otg pin function enable
// - otg needs register bit, optionally pin
// - seamless path select, 2 bits
// - done flag set, cleared by read
`timescale 1ns/1ps
module cac_aux_regs
  import cac_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2a,
  // arbitrary identifier value
  parameter logic [3:0] PART_ID = 4'h9,
  parameter int unsigned SDA_TIMEOUT_CYCLES = SDA_TIMEOUT_CYC,
  parameter int unsigned LONG_PRESS_CYCLES = LONG_PRESS_CYC,
  parameter int unsigned EOC_SHORT_CYCLES = EOC_SHORT_CYC,
  parameter int unsigned EOC_LONG_CYCLES = EOC_LONG_CYC,
  parameter int unsigned ADAPTER_REQ_CYCLES = ADAPTER_REQ_CYC
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_WDT_RESET,
  input wire logic I_REG_RESET,
  // serial host port
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_O,
  output logic O_SDA_OE_N,
  // converter readings
  input wire logic [15:0] I_DIE_TEMPERATURE,
  input wire logic [15:0] I_PLUS_LINE_MV,
  input wire logic [15:0] I_MINUS_LINE_MV,
  // charger status inputs
  input wire logic I_PUSH_BUTTON_INPUT,
  input wire logic I_BUS_INPUT_PRESENT,
  input wire logic I_CHARGE_DONE_RAW,
  input wire logic I_OTG_PIN,
  input wire logic I_OTG_REGISTER_ENABLE,
  input wire logic I_PORT_DETECT_DONE,
  input wire logic I_ZONE_COOL,
  input wire logic I_ZONE_COLD_HOT,
  // data line drive
  output logic [2:0] O_PLUS_LINE_DRIVE_SEL,
  output logic [2:0] O_MINUS_LINE_DRIVE_SEL,
  // adapter request engine
  output logic O_ADAPTER_REQUEST_ACTIVE,
  output logic O_ADAPTER_PROTOCOL_GEN_SEL,
  output logic O_GEN1_VOLTAGE_DIRECTION,
  output logic [4:0] O_GEN2_VOLTAGE_CODE,
  output logic [15:0] O_GEN2_TARGET_MV,
  output logic O_GEN2_SELF_TEST,
  output logic O_GEN2_NO_DROP_COMP,
  // charger control
  output logic O_SHIP_SWITCH_OPEN,
  output logic O_LOAD_INPUT_CURRENT_LIMIT,
  output logic O_SET_INPUT_VOLTAGE_FLOOR,
  output logic O_CHARGE_DONE,
  output logic O_BATT_REG_FROM_WARM,
  output logic O_EXTREME_ZONE_HALT,
  output logic O_FREQ_FORCE_1MHZ,
  output logic O_OTG_MODE,
  output logic [1:0] O_SEAMLESS_SEL
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    cac_bus_st_t st;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] btn_sy;
    logic [1:0] bus_sy;
    logic [1:0] eoc_sy;
    logic [1:0] otg_sy;
    logic scl_p;
    logic sda_p;
    logic bus_p;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic rw;
    logic mack;
    logic [7:0] ptr;
    logic sda_drv;
    logic [5:0] drive;
    logic [7:0] req;
    logic [7:0] ctrl0;
    logic [4:0] ctrl1;
    logic done_flag;
    logic [31:0] pe_cnt;
    logic eoc_state;
    logic ship_req;
    logic load_icl;
    logic set_floor;
    logic [15:0] target_mv;
    logic from_warm;
    logic halt;
    logic otg_mode;
  } cac_regs_t;

  cac_regs_t s_r;
  cac_regs_t s_nxt;

  logic sda_timeout;
  logic press_done;
  logic degl_done;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  // ************************************************************
  // hold timers
  // ************************************************************
  // counter of the target holding sda low
  cac_hold_timer u_sda_hold (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_active(s_r.sda_drv & ~s_r.ctrl0[POS_BUS_TO_DIS]),
    .i_limit(32'(SDA_TIMEOUT_CYCLES)),
    .o_expired(sda_timeout)
  );

  cac_hold_timer u_press_hold (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_active(~s_r.btn_sy[1] & s_r.ctrl0[POS_LONG_PRESS]),
    .i_limit(32'(LONG_PRESS_CYCLES)),
    .o_expired(press_done)
  );

  cac_hold_timer u_eoc_hold (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_active(s_r.eoc_sy[1] & ~s_r.eoc_state & ~s_r.ctrl0[POS_EOC_RST]),
    .i_limit(s_r.ctrl0[POS_EOC_DEGL] ? 32'(EOC_LONG_CYCLES) : 32'(EOC_SHORT_CYCLES)),
    .o_expired(degl_done)
  );

  // ************************************************************
  // read data
  // ************************************************************
  // the pointer moves before a follow-on byte is loaded
  assign rd_addr = (s_r.st == ST_RDATA_ACK) ? s_r.ptr + 8'h01 : s_r.ptr;

  always_comb begin
    case (rd_addr)
      ADDR_DIE_TEMP_HI: rd_data = I_DIE_TEMPERATURE[15:8];
      ADDR_DIE_TEMP_LO: rd_data = I_DIE_TEMPERATURE[7:0];
      ADDR_PLUS_MV_HI: rd_data = I_PLUS_LINE_MV[15:8];
      ADDR_PLUS_MV_LO: rd_data = I_PLUS_LINE_MV[7:0];
      ADDR_MINUS_MV_HI: rd_data = I_MINUS_LINE_MV[15:8];
      ADDR_MINUS_MV_LO: rd_data = I_MINUS_LINE_MV[7:0];
      ADDR_LINE_DRIVE: rd_data = {s_r.drive, 2'h0};
      ADDR_PART_INFO: rd_data = {1'b0, PART_ID, 3'h0};
      ADDR_ADAPTER_REQ: rd_data = s_r.req;
      ADDR_CTRL_ZERO: rd_data = s_r.ctrl0;
      ADDR_CTRL_ONE: rd_data = {3'h0, s_r.ctrl1};
      ADDR_DONE_FLAGS: rd_data = {3'h0, s_r.done_flag, 4'h0};
      default: rd_data = 8'h00;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic wr_en;
    logic load;
    scl_rise = s_r.scl_sy[1] & ~s_r.scl_p;
    scl_fall = ~s_r.scl_sy[1] & s_r.scl_p;
    start_c = s_r.scl_sy[1] & s_r.scl_p & s_r.sda_p & ~s_r.sda_sy[1];
    stop_c = s_r.scl_sy[1] & s_r.scl_p & ~s_r.sda_p & s_r.sda_sy[1];
    wr_en = 1'b0;
    load = 1'b0;
    s_nxt = s_r;
    s_nxt.scl_sy = {s_r.scl_sy[0], I_SCL};
    s_nxt.sda_sy = {s_r.sda_sy[0], I_SDA};
    s_nxt.btn_sy = {s_r.btn_sy[0], I_PUSH_BUTTON_INPUT};
    s_nxt.bus_sy = {s_r.bus_sy[0], I_BUS_INPUT_PRESENT};
    s_nxt.eoc_sy = {s_r.eoc_sy[0], I_CHARGE_DONE_RAW};
    s_nxt.otg_sy = {s_r.otg_sy[0], I_OTG_PIN};
    s_nxt.scl_p = s_r.scl_sy[1];
    s_nxt.sda_p = s_r.sda_sy[1];
    s_nxt.bus_p = s_r.bus_sy[1];
    s_nxt.ship_req = 1'b0;
    s_nxt.load_icl = 1'b0;
    s_nxt.set_floor = 1'b0;

    // serial target; the timeout, a start or a stop each clears a transfer, the timeout first
    if (sda_timeout) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_drv = 1'b0;
    end else if (start_c) begin
      s_nxt.st = ST_ADDR;
      s_nxt.bitcnt = 4'h0;
      s_nxt.sda_drv = 1'b0;
    end else if (stop_c) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_drv = 1'b0;
    end else if (scl_rise) begin
      case (s_r.st)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          s_nxt.shift = {s_r.shift[6:0], s_r.sda_sy[1]};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        ST_RDATA: s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        ST_RDATA_ACK: s_nxt.mack = ~s_r.sda_sy[1];
        default: ;
      endcase
    end else if (scl_fall) begin
      case (s_r.st)
        ST_ADDR: begin
          if (s_r.bitcnt == 4'h8) begin
            if (s_r.shift[7:1] == TARGET_ADDR) begin
              s_nxt.sda_drv = 1'b1;
              s_nxt.rw = s_r.shift[0];
              s_nxt.st = ST_ADDR_ACK;
            end else begin
              s_nxt.st = ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (s_r.bitcnt == 4'h8) begin
            s_nxt.sda_drv = 1'b1;
            s_nxt.ptr = s_r.shift;
            s_nxt.st = ST_PTR_ACK;
          end
        end
        ST_WDATA: begin
          if (s_r.bitcnt == 4'h8) begin
            s_nxt.sda_drv = 1'b1;
            wr_en = 1'b1;
            s_nxt.st = ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK: begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.rw) begin
            load = 1'b1;
          end else begin
            s_nxt.sda_drv = 1'b0;
            s_nxt.st = ST_PTR;
          end
        end
        ST_PTR_ACK: begin
          s_nxt.sda_drv = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.st = ST_WDATA;
        end
        ST_WDATA_ACK: begin
          s_nxt.sda_drv = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.ptr = s_r.ptr + 8'h01;
          s_nxt.st = ST_WDATA;
        end
        ST_RDATA: begin
          if (s_r.bitcnt == 4'h8) begin
            s_nxt.sda_drv = 1'b0;
            s_nxt.st = ST_RDATA_ACK;
          end else begin
            s_nxt.shift = {s_r.shift[6:0], 1'b0};
            s_nxt.sda_drv = ~s_r.shift[6];
          end
        end
        ST_RDATA_ACK: begin
          if (s_r.mack) begin
            s_nxt.ptr = s_r.ptr + 8'h01;
            load = 1'b1;
          end else begin
            s_nxt.st = ST_IDLE;
          end
        end
        default: s_nxt.st = ST_IDLE;
      endcase
    end

    if (load) begin
      s_nxt.shift = rd_data;
      s_nxt.sda_drv = ~rd_data[7];
      s_nxt.bitcnt = 4'h0;
      s_nxt.st = ST_RDATA;
      if (rd_addr == ADDR_DONE_FLAGS) begin
        s_nxt.done_flag = 1'b0;
      end
    end

    // register writes; read-only offsets ignore the byte
    if (wr_en) begin
      case (s_r.ptr)
        ADDR_LINE_DRIVE: s_nxt.drive = s_r.shift[7:2];
        ADDR_ADAPTER_REQ: begin
          s_nxt.req = s_r.shift;
          s_nxt.req[POS_REQ_GO] = s_r.req[POS_REQ_GO] | s_r.shift[POS_REQ_GO];
        end
        ADDR_CTRL_ZERO: begin
          s_nxt.ctrl0 = s_r.shift;
          s_nxt.ctrl0[POS_EOC_RST] = s_r.ctrl0[POS_EOC_RST] | s_r.shift[POS_EOC_RST];
        end
        ADDR_CTRL_ONE: s_nxt.ctrl1 = s_r.shift[4:0];
        default: ;
      endcase
    end

    if (s_r.req[POS_REQ_GO]) begin
      if (s_r.pe_cnt + 32'h1 >= 32'(ADAPTER_REQ_CYCLES)) begin
        s_nxt.req[POS_REQ_GO] = 1'b0;
        s_nxt.pe_cnt = 32'h0;
        s_nxt.done_flag = 1'b1;
      end else begin
        s_nxt.pe_cnt = s_r.pe_cnt + 32'h1;
      end
    end else begin
      s_nxt.pe_cnt = 32'h0;
    end
    if (!s_r.bus_sy[1]) begin
      s_nxt.req[POS_REQ_GO] = 1'b0;
      s_nxt.pe_cnt = 32'h0;
    end

    if (degl_done) begin
      s_nxt.eoc_state = 1'b1;
    end
    if (s_r.ctrl0[POS_EOC_RST]) begin
      s_nxt.eoc_state = 1'b0;
      s_nxt.ctrl0[POS_EOC_RST] = 1'b0;
    end

    s_nxt.ship_req = press_done;
    s_nxt.load_icl = I_PORT_DETECT_DONE & s_r.ctrl0[POS_AUTO_ICL];
    s_nxt.set_floor = s_r.bus_sy[1] & ~s_r.bus_p & s_r.ctrl0[POS_AUTO_FLOOR];

    if (I_REG_RESET) begin
      s_nxt.req = RST_ADAPTER_REQ;
      s_nxt.ctrl0 = RST_CTRL_ZERO;
      s_nxt.ctrl1 = RST_CTRL_ONE;
      s_nxt.pe_cnt = 32'h0;
    end else if (I_WDT_RESET) begin
      // frequency override survives the watchdog
      s_nxt.req = RST_ADAPTER_REQ;
      s_nxt.ctrl0 = RST_CTRL_ZERO;
      s_nxt.ctrl1[3:0] = RST_CTRL_ONE[3:0];
      s_nxt.pe_cnt = 32'h0;
    end

    if (s_nxt.req[4:0] <= GEN2_TOP_CODE) begin
      s_nxt.target_mv = GEN2_BASE_MV + 16'(s_nxt.req[4:0]) * GEN2_STEP_MV;
    end else begin
      s_nxt.target_mv = 16'h0000;
    end
    s_nxt.from_warm = I_ZONE_COOL & ~s_nxt.ctrl0[POS_COOL_SEL];
    s_nxt.halt = I_ZONE_COLD_HOT & ~s_nxt.ctrl0[POS_EXTREME];
    if (s_nxt.ctrl1[POS_OTG_GATE]) begin
      s_nxt.otg_mode = I_OTG_REGISTER_ENABLE & s_nxt.ctrl1[POS_OTG_INPUT_PIN_ENABLE] & s_r.otg_sy[1];
    end else begin
      s_nxt.otg_mode = I_OTG_REGISTER_ENABLE;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.ctrl0 <= RST_CTRL_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign O_SDA_O = 1'b0;
  assign O_SDA_OE_N = ~s_r.sda_drv;
  // field decode to the line drivers
  assign O_PLUS_LINE_DRIVE_SEL = s_r.drive[POS_PLUS_DRIVE-2 +: 3];
  assign O_MINUS_LINE_DRIVE_SEL = s_r.drive[POS_MINUS_DRIVE-2 +: 3];
  assign O_ADAPTER_REQUEST_ACTIVE = s_r.req[POS_REQ_GO];
  assign O_ADAPTER_PROTOCOL_GEN_SEL = s_r.req[POS_GEN_SEL];
  assign O_GEN1_VOLTAGE_DIRECTION = s_r.req[POS_GEN1_DIR];
  assign O_GEN2_VOLTAGE_CODE = s_r.req[4:0];
  assign O_GEN2_TARGET_MV = s_r.target_mv;
  assign O_GEN2_SELF_TEST = (s_r.req[4:0] == GEN2_SELF_TEST);
  assign O_GEN2_NO_DROP_COMP = (s_r.req[4:0] == GEN2_NO_DROP_COMP);
  assign O_SHIP_SWITCH_OPEN = s_r.ship_req;
  assign O_LOAD_INPUT_CURRENT_LIMIT = s_r.load_icl;
  assign O_SET_INPUT_VOLTAGE_FLOOR = s_r.set_floor;
  assign O_CHARGE_DONE = s_r.eoc_state;
  assign O_BATT_REG_FROM_WARM = s_r.from_warm;
  assign O_EXTREME_ZONE_HALT = s_r.halt;
  assign O_FREQ_FORCE_1MHZ = s_r.ctrl1[POS_FREQ_1MHZ];
  assign O_OTG_MODE = s_r.otg_mode;
  assign O_SEAMLESS_SEL = s_r.ctrl1[1:0];

endmodule // cac_aux_regs

//--- sim/cac_host_model.sv
// serial host model for the charger register bank
// assumes a pulled-up data wire and the reference clock
`timescale 1ns/1ps
module cac_host_model #(
  parameter logic [6:0] DEV = 7'h2a
) (
  input wire logic i_clk,
  input wire logic i_sda_oe_n,
  output logic o_scl,
  output logic o_sda
);
  // *****
  // wire and bit timing
  // *****
  logic drv = 1'b1;
  initial o_scl = 1'b1;
  // pull-up: the wire is low only while some party pulls it
  assign o_sda = drv & i_sda_oe_n;
  task automatic pace(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // 6-clock phases cover the two-stage sync
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    pace(6);
    o_scl = 1'b1;
    pace(6);
    r = o_sda;
    o_scl = 1'b0;
    pace(2);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, n);
  endtask
  task automatic start();
    drv = 1'b1;
    pace(2);
    o_scl = 1'b1;
    pace(6);
    drv = 1'b0;
    pace(6);
    o_scl = 1'b0;
    pace(2);
  endtask
  task automatic stop();
    drv = 1'b0;
    pace(2);
    o_scl = 1'b1;
    pace(6);
    drv = 1'b1;
    pace(6);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                    output logic nak);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, n0);
    byte_io(a, 1'b1, q, n1);
    byte_io(d, 1'b1, q, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  // single byte, nacked
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic n;
    start();
    byte_io({DEV, 1'b0}, 1'b1, d, n);
    byte_io(a, 1'b1, d, n);
    start();
    byte_io({DEV, 1'b1}, 1'b1, d, n);
    byte_io(8'hff, 1'b1, d, n);
    stop();
  endtask
endmodule // cac_host_model

//--- sim/cac_aux_regs_assertions.sv
// port checker for the charger register bank
// assumes a bind into cac_aux_regs
`timescale 1ns/1ps
module cac_aux_regs_assertions #(
  parameter int unsigned SDA_TIMEOUT_CYCLES = 200,
  parameter int unsigned ADAPTER_REQ_CYCLES = 30
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_WDT_RESET,
  input wire logic I_REG_RESET,
  input wire logic I_PUSH_BUTTON_INPUT,
  input wire logic I_BUS_INPUT_PRESENT,
  input wire logic I_CHARGE_DONE_RAW,
  input wire logic I_OTG_REGISTER_ENABLE,
  input wire logic I_PORT_DETECT_DONE,
  input wire logic O_SDA_OE_N,
  input wire logic [2:0] O_PLUS_LINE_DRIVE_SEL,
  input wire logic O_ADAPTER_REQUEST_ACTIVE,
  input wire logic [4:0] O_GEN2_VOLTAGE_CODE,
  input wire logic [15:0] O_GEN2_TARGET_MV,
  input wire logic O_SHIP_SWITCH_OPEN,
  input wire logic O_LOAD_INPUT_CURRENT_LIMIT,
  input wire logic O_CHARGE_DONE,
  input wire logic O_OTG_MODE,
  input wire logic [1:0] O_SEAMLESS_SEL
);
  // *****
  // assertions
  // *****
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  logic [31:0] low_cnt, req_cnt;
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      low_cnt <= '0;
      req_cnt <= '0;
    end else begin
      low_cnt <= O_SDA_OE_N ? '0 : low_cnt + 32'h1;
      req_cnt <= O_ADAPTER_REQUEST_ACTIVE ? req_cnt + 32'h1 : '0;
    end
  end
  a_sda_low_limit: assert property (low_cnt <= SDA_TIMEOUT_CYCLES + 4)
    else $error("sda low too long");
  a_req_self_clear: assert property (req_cnt <= ADAPTER_REQ_CYCLES + 2)
    else $error("go stuck");
  a_req_bus_gone: assert property (!I_BUS_INPUT_PRESENT [*4] ##1
    O_ADAPTER_REQUEST_ACTIVE |-> ##[1:2] !O_ADAPTER_REQUEST_ACTIVE)
    else $error("go kept, no bus");
  a_ship_one_pulse: assert property (O_SHIP_SWITCH_OPEN |->
    $past(I_PUSH_BUTTON_INPUT, 8) == 1'b0 ##1 !O_SHIP_SWITCH_OPEN)
    else $error("ship without press");
  a_icl_after_detect: assert property (O_LOAD_INPUT_CURRENT_LIMIT |->
    $past(I_PORT_DETECT_DONE)) else $error("load without detect");
  a_eoc_deglitch: assert property ($rose(O_CHARGE_DONE) |->
    $past(I_CHARGE_DONE_RAW, 18)) else $error("done too early");
  a_gen2_ladder: assert property ($past(I_NRST) && $stable(O_GEN2_VOLTAGE_CODE) &&
    O_GEN2_VOLTAGE_CODE <= 5'h1d |-> O_GEN2_TARGET_MV == 16'h157c + 16'h01f4 *
    O_GEN2_VOLTAGE_CODE) else $error("target off ladder");
  a_otg_needs_reg: assert property (O_OTG_MODE |-> $past(I_OTG_REGISTER_ENABLE))
    else $error("otg without enable");
  a_reset_defaults: assert property (I_WDT_RESET || I_REG_RESET |=>
    O_SEAMLESS_SEL == 2'h0 && $stable(O_PLUS_LINE_DRIVE_SEL))
    else $error("reset fields wrong");
  c_ship: cover property (O_SHIP_SWITCH_OPEN);
  c_done: cover property ($rose(O_CHARGE_DONE));
  c_req: cover property ($fell(O_ADAPTER_REQUEST_ACTIVE));
endmodule // cac_aux_regs_assertions

bind cac_aux_regs cac_aux_regs_assertions #(
  .SDA_TIMEOUT_CYCLES(SDA_TIMEOUT_CYCLES),
  .ADAPTER_REQ_CYCLES(ADAPTER_REQ_CYCLES)
) chk (.*);

//--- sim/cac_aux_regs_test.sv
// self-checking bench for the charger register bank
// assumes the host model paces serial traffic from the bench clock
`timescale 1ns/1ps
module cac_aux_regs_test import cac_pkg::*;;
  // *****
  // stimulus and design
  // *****
  // arbitrary identifier value
  localparam logic [3:0] PID = 4'h5;
  logic clk = 1'b0, nrst = 1'b0, wdt = 1'b0, rrst = 1'b0, btn = 1'b1, bus = 1'b0, eoc = 1'b0;
  logic otg_pin = 1'b0, otg_reg = 1'b0, det = 1'b0, cool = 1'b0, coldhot = 1'b0, nk;
  logic [15:0] die_temperature = 16'hfff6, pmv = 16'h1234, mmv = 16'h0abc;
  logic [7:0] q;
  logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h1d, 5'h1e, 5'h1f};
  wire scl, sda, oe_n, gsel, gdir, stst, ndc, ship, icl, flr, done, warm, halt, f1m, otg, act;
  wire [2:0] pdrv, mdrv;
  wire [4:0] gcode;
  wire [15:0] tmv;
  wire [1:0] seam;
  int miscompares = 0, cmp_count = 0, ships = 0, floors = 0;
  initial forever #25 clk = ~clk;
  cac_aux_regs #(.PART_ID(PID), .SDA_TIMEOUT_CYCLES(200),
    .LONG_PRESS_CYCLES(300), .EOC_SHORT_CYCLES(20), .EOC_LONG_CYCLES(50),
    .ADAPTER_REQ_CYCLES(30)) uut (.I_REF_CLK(clk), .I_NRST(nrst), .I_WDT_RESET(wdt),
    .I_REG_RESET(rrst), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(), .O_SDA_OE_N(oe_n),
    .I_DIE_TEMPERATURE(die_temperature), .I_PLUS_LINE_MV(pmv), .I_MINUS_LINE_MV(mmv),
    .I_PUSH_BUTTON_INPUT(btn), .I_BUS_INPUT_PRESENT(bus), .I_CHARGE_DONE_RAW(eoc),
    .I_OTG_PIN(otg_pin), .I_OTG_REGISTER_ENABLE(otg_reg), .I_PORT_DETECT_DONE(det),
    .I_ZONE_COOL(cool), .I_ZONE_COLD_HOT(coldhot), .O_PLUS_LINE_DRIVE_SEL(pdrv),
    .O_MINUS_LINE_DRIVE_SEL(mdrv), .O_ADAPTER_REQUEST_ACTIVE(act),
    .O_ADAPTER_PROTOCOL_GEN_SEL(gsel), .O_GEN1_VOLTAGE_DIRECTION(gdir),
    .O_GEN2_VOLTAGE_CODE(gcode), .O_GEN2_TARGET_MV(tmv), .O_GEN2_SELF_TEST(stst),
    .O_GEN2_NO_DROP_COMP(ndc), .O_SHIP_SWITCH_OPEN(ship), .O_LOAD_INPUT_CURRENT_LIMIT(icl),
    .O_SET_INPUT_VOLTAGE_FLOOR(flr), .O_CHARGE_DONE(done), .O_BATT_REG_FROM_WARM(warm),
    .O_EXTREME_ZONE_HALT(halt), .O_FREQ_FORCE_1MHZ(f1m), .O_OTG_MODE(otg),
    .O_SEAMLESS_SEL(seam));
  cac_host_model host (.i_clk(clk), .i_sda_oe_n(oe_n), .o_scl(scl),
    .o_sda(sda));
  always @(posedge clk) begin
    ships <= ships + int'(ship);
    floors <= floors + int'(flr);
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q);
    cmp(q, e);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.wr(7'h2a, a, d, nk);
    cmp(nk, 1'b0);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic press(input logic [31:0] n);
    btn = 1'b0;
    repeat (320) @(negedge clk);
    btn = 1'b1;
    cmp(ships, n);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  // *****
  // tests
  // *****
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    bus = 1'b1;
    repeat (4) @(negedge clk);
    chk(ADDR_CTRL_ZERO, 8'h76);
    chk(ADDR_CTRL_ONE, 8'h00);
    chk(ADDR_PART_INFO, {1'b0, PID, 3'h0});
    chk(8'h4c, 8'h00);
    chk(ADDR_DIE_TEMP_HI, 8'hff);
    chk(ADDR_DIE_TEMP_LO, 8'hf6);
    die_temperature = 16'h0019;
    chk(ADDR_DIE_TEMP_LO, 8'h19);
    put(ADDR_PLUS_MV_HI, 8'h55);
    chk(ADDR_PLUS_MV_HI, 8'h12);
    chk(ADDR_MINUS_MV_LO, 8'hbc);
    put(ADDR_LINE_DRIVE, 8'hcb);
    cmp({pdrv, mdrv}, 6'h32);
    chk(ADDR_LINE_DRIVE, 8'hc8);
    foreach (codes[i]) begin
      put(ADDR_ADAPTER_REQ, {3'b010, codes[i]});
      cmp({gsel, gcode, stst, ndc, tmv}, {1'b1, codes[i], codes[i] == 5'h1e,
        codes[i] == 5'h1f, codes[i] > 5'h1d ? 16'h0 : 16'h157c + 16'h01f4 * codes[i]});
    end
    put(ADDR_ADAPTER_REQ, 8'h20);
    cmp({gsel, gdir}, 2'b01);
    put(ADDR_ADAPTER_REQ, 8'h80);
    cmp(act, 1'b1);
    chk(ADDR_ADAPTER_REQ, 8'h00);
    chk(ADDR_DONE_FLAGS, 8'h10);
    chk(ADDR_DONE_FLAGS, 8'h00);
    bus = 1'b0;
    put(ADDR_ADAPTER_REQ, 8'h80);
    chk(ADDR_DONE_FLAGS, 8'h00);
    bus = 1'b1;
    otg_reg = 1'b1;
    put(ADDR_CTRL_ONE, 8'h1d);
    cmp({f1m, seam, otg}, 4'b1010);
    otg_pin = 1'b1;
    chk(ADDR_CTRL_ONE, 8'h1d);
    cmp(otg, 1'b1);
    otg_pin = 1'b0;
    put(ADDR_CTRL_ONE, 8'h12);
    cmp({f1m, seam, otg}, 4'b1101);
    cool = 1'b1;
    coldhot = 1'b1;
    repeat (4) @(negedge clk);
    cmp({warm, halt}, 2'b01);
    put(ADDR_CTRL_ZERO, 8'h75);
    cmp({warm, halt}, 2'b10);
    pulse(wdt);
    chk(ADDR_CTRL_ONE, 8'h10);
    chk(ADDR_CTRL_ZERO, 8'h76);
    chk(ADDR_LINE_DRIVE, 8'hc8);
    pulse(rrst);
    chk(ADDR_CTRL_ONE, 8'h00);
    eoc = 1'b1;
    repeat (40) @(negedge clk);
    cmp(done, 1'b0);
    repeat (20) @(negedge clk);
    cmp(done, 1'b1);
    eoc = 1'b0;
    put(ADDR_CTRL_ZERO, 8'h6e);
    cmp(done, 1'b0);
    chk(ADDR_CTRL_ZERO, 8'h66);
    eoc = 1'b1;
    repeat (30) @(negedge clk);
    cmp(done, 1'b1);
    press(1);
    put(ADDR_CTRL_ZERO, 8'h26);
    press(1);
    pulse(det);
    cmp(icl, 1'b1);
    cmp(floors, 2);
    host.wr(7'h2b, ADDR_CTRL_ONE, 8'h1f, nk);
    cmp(nk, 1'b1);
    chk(ADDR_CTRL_ONE, 8'h00);
    wrap_up();
  end
endmodule // cac_aux_regs_test
